// *** pbc_pkg.sv ***
// constants and types of the prbs self-test and loopback control block
// assumes a 32-bit apb slave port and one 50 MHz core clock
//
// Overview of operation
// - counter mode 1: at maximum, pulse and restart counting from zero.
// - counter mode 0: error counter saturates at maximum and stops.
// - type 1 and enabled: continuous prbs packets; checker also stays active while disabled.
// - type 0 and enabled: one constant-data packet; prbs generate/check disabled.
// - enable bit 1 starts the generator, 0 stops it.
// - lock bit reads 1 while the checker is synced to received bits.
// - sync-loss bit latches on loss of sync until the register is read.
// - generator status reads 1 while packets are being produced.
// - loopback select one-hot: none, pcs, analog, reverse; 1000 reserved.
// - in mac loopback bit 6 forwards data to line, else suppressed.
// - bit 6 accepted as 1 only while mac loopback is active.
package pbc_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0]  IDX_CTRL  = 8'h16;
	localparam logic [7:0]  IDX_ERRS  = 8'h20;
	localparam logic [7:0]  IDX_ISTAT = 8'h21;
	localparam logic [7:0]  IDX_IMASK = 8'h22;
	localparam logic [11:0] ADR_CTRL  = {2'h0, IDX_CTRL, 2'h0};
	localparam logic [11:0] ADR_ERRS  = {2'h0, IDX_ERRS, 2'h0};
	localparam logic [11:0] ADR_ISTAT = {2'h0, IDX_ISTAT, 2'h0};
	localparam logic [11:0] ADR_IMASK = {2'h0, IDX_IMASK, 2'h0};
	// control register fields
	localparam int B_MODE = 14;
	localparam int B_TYPE = 13;
	localparam int B_EN   = 12;
	localparam int B_LOCK = 11;
	localparam int B_LOSS = 10;
	localparam int B_GACT = 9;
	localparam int B_RSVH = 7;
	localparam int B_FWD  = 6;
	localparam int B_SEL  = 2;
	localparam logic [1:0]  RSVH_VAL   = 2'h2;
	localparam logic [15:0] CTRL_RESET = 16'h0100;
	// interrupt status / mask bits
	localparam int I_LOSS = 0;
	localparam int I_WRAP = 1;
	localparam int I_DONE = 2;
	localparam int IRQ_W  = 3;
	// loopback codes
	localparam logic [3:0] LB_NORMAL  = 4'h0;
	localparam logic [3:0] LB_PCS     = 4'h1;
	localparam logic [3:0] LB_ANALOG  = 4'h2;
	localparam logic [3:0] LB_REVERSE = 4'h4;
	// sequence and packet shape
	localparam int PRBS_W = 15;
	localparam logic [14:0] PRBS_SEED = 15'h7fff;
	localparam logic [11:0] PKT_LEN   = 12'h200;
	localparam logic [11:0] GAP_LEN   = 12'h060;
	localparam logic [7:0]  CONST_BYTE = 8'ha5;
	localparam logic [5:0]  LOCK_RUN  = 6'h20;
	localparam logic [2:0]  LOSS_RUN  = 3'h4;
	localparam logic [15:0] ERR_MAX   = 16'hffff;

	typedef struct packed {
		logic pcs;
		logic analog;
		logic reverse;
	} pbc_loop_type;

	typedef enum logic [2:0] {
		G_IDLE = 3'b001,
		G_SEND = 3'b010,
		G_GAP  = 3'b100
	} pbc_gen_type;
endpackage

// *** pbc_bist_ctrl.sv ***
// prbs packet generator, checker, error counter and loopback selector
// assumes apb master on ref_clk; rx pins asynchronous; macLoopActive on ref_clk
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module pbc_bist_ctrl (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// line side
	input  wire logic              rxBit,
	input  wire logic              rxValid,
	output logic                   txBit,
	output logic                   txValid,
	output logic                   lineTxEn,
	// loopback and mac interface
	input  wire logic              macLoopActive,
	output pbc_pkg::pbc_loop_type  loopSel,
	// events
	output logic                   errWrapPulse,
	output logic                   irq
);
	import pbc_pkg::*;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
		hit = (a == r);
	endfunction

	logic              rstA_q, rstN_q;
	logic [1:0]        rxBitS_q, rxValS_q;
	logic              mode_q, type_q, en_q, fwd_q;
	logic [3:0]        sel_q;
	logic [1:0]        rsvL_q;
	logic              lossFlag_q, lock_q;
	logic [IRQ_W-1:0]  iStat_q, iMask_q;
	logic [15:0]       errCnt_q;
	pbc_gen_type       genState_q;
	logic [11:0]       bitCnt_q;
	logic [14:0]       genLfsr_q, chkLfsr_q;
	logic              oneDone_q;
	logic [5:0]        matchRun_q;
	logic [2:0]        badRun_q;
	logic              access, done, wrDone, rdDone, badAdr;
	logic              checkEn, rxStep, pred, miss, errEvt, lossEvt, doneEvt;
	logic              pktEnd, ctrlRd;
	logic [31:0]       rdMux;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstN_q);

	////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rstA_q <= 1'b0;
			rstN_q <= 1'b0;
		end else begin
			rstA_q <= 1'b1;
			rstN_q <= rstA_q;
		end
	end

	always_ff @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			rxBitS_q <= 2'h0;
			rxValS_q <= 2'h0;
		end else begin
			rxBitS_q <= {rxBitS_q[0], rxBit};
			rxValS_q <= {rxValS_q[0], rxValid};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb: one wait state, so read data and side effects line up with pready
	assign access = psel && penable;
	assign done   = access && pready;
	assign badAdr = !(hit(paddr, ADR_CTRL) || hit(paddr, ADR_ERRS)
		|| hit(paddr, ADR_ISTAT) || hit(paddr, ADR_IMASK));
	assign wrDone = done && pwrite && !badAdr;
	assign rdDone = done && !pwrite;
	assign ctrlRd = rdDone && hit(paddr, ADR_CTRL);

	always_comb begin
		rdMux = 32'h0;
		if (hit(paddr, ADR_CTRL)) begin
			rdMux[B_MODE] = mode_q;
			rdMux[B_TYPE] = type_q;
			rdMux[B_EN]   = en_q;
			rdMux[B_LOCK] = lock_q;
			rdMux[B_LOSS] = lossFlag_q;
			rdMux[B_GACT] = (genState_q != G_IDLE);
			rdMux[B_RSVH+1:B_RSVH] = RSVH_VAL;
			rdMux[B_FWD]  = fwd_q;
			rdMux[B_SEL+3:B_SEL] = sel_q;
			rdMux[1:0]    = rsvL_q;
		end else if (hit(paddr, ADR_ERRS)) begin
			rdMux[15:0] = errCnt_q;
		end else if (hit(paddr, ADR_ISTAT)) begin
			rdMux[IRQ_W-1:0] = iStat_q;
		end else if (hit(paddr, ADR_IMASK)) begin
			rdMux[IRQ_W-1:0] = iMask_q;
		end
	end

	always_ff @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= access && !pready;
			pslverr <= access && !pready && badAdr;
			if (access && !pready && !pwrite) begin
				prdata <= rdMux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control register writes
	always_ff @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			mode_q <= CTRL_RESET[B_MODE];
			type_q <= CTRL_RESET[B_TYPE];
			en_q   <= CTRL_RESET[B_EN];
			fwd_q  <= CTRL_RESET[B_FWD];
			sel_q  <= CTRL_RESET[B_SEL+3:B_SEL];
			rsvL_q <= CTRL_RESET[1:0];
		end else if (wrDone && hit(paddr, ADR_CTRL)) begin
			if (pstrb[1]) begin
				mode_q <= pwdata[B_MODE];
				type_q <= pwdata[B_TYPE];
				en_q   <= pwdata[B_EN];
			end
			if (pstrb[0]) begin
				// a 1 only sticks while the mac side is looped back
				fwd_q  <= pwdata[B_FWD] && macLoopActive;
				sel_q  <= pwdata[B_SEL+3:B_SEL];
				rsvL_q <= pwdata[1:0];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			iMask_q <= '0;
		end else if (wrDone && hit(paddr, ADR_IMASK) && pstrb[0]) begin
			iMask_q <= pwdata[IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// loopback selection and line gating
	always_ff @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			loopSel  <= '0;
			lineTxEn <= 1'b1;
		end else begin
			// reserved and multi-hot codes fall back to normal operation
			loopSel.pcs     <= (sel_q == LB_PCS);
			loopSel.analog  <= (sel_q == LB_ANALOG);
			loopSel.reverse <= (sel_q == LB_REVERSE);
			lineTxEn <= !macLoopActive || fwd_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// packet generator
	assign pktEnd  = (genState_q == G_SEND) && (bitCnt_q == PKT_LEN - 12'h1);
	assign doneEvt = pktEnd && !type_q;

	always_ff @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			genState_q <= G_IDLE;
			bitCnt_q   <= 12'h0;
		end else if (!en_q) begin
			genState_q <= G_IDLE;
			bitCnt_q   <= 12'h0;
		end else begin
			bitCnt_q <= bitCnt_q + 12'h1;
			case (genState_q)
				G_IDLE: begin
					bitCnt_q <= 12'h0;
					if (type_q || !oneDone_q) begin
						genState_q <= G_SEND;
					end
				end
				G_SEND: begin
					if (pktEnd) begin
						bitCnt_q   <= 12'h0;
						genState_q <= type_q ? G_GAP : G_IDLE;
					end
				end
				G_GAP: begin
					if (bitCnt_q == GAP_LEN - 12'h1) begin
						bitCnt_q   <= 12'h0;
						genState_q <= G_SEND;
					end
				end
				default: begin
					genState_q <= G_IDLE;
				end
			endcase
		end
	end

	// single packet is sent once per enable
	always_ff @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			oneDone_q <= 1'b0;
		end else if (!en_q || type_q) begin
			oneDone_q <= 1'b0;
		end else if (doneEvt) begin
			oneDone_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			genLfsr_q <= PRBS_SEED;
			txBit     <= 1'b0;
			txValid   <= 1'b0;
		end else begin
			txValid <= (genState_q == G_SEND) && lineTxEn;
			if (genState_q == G_SEND && type_q) begin
				// x^15 + x^14 + 1, shared with the checker
				genLfsr_q <= {genLfsr_q[13:0], genLfsr_q[14] ^ genLfsr_q[13]};
				txBit     <= genLfsr_q[14] ^ genLfsr_q[13];
			end else begin
				txBit <= (genState_q == G_SEND) && CONST_BYTE[bitCnt_q[2:0]];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checker: self-synchronising, so any phase of the stream locks
	assign checkEn = !(en_q && !type_q);
	assign rxStep  = checkEn && rxValS_q[1];
	assign pred    = chkLfsr_q[14] ^ chkLfsr_q[13];
	assign miss    = rxStep && (pred != rxBitS_q[1]);
	assign errEvt  = miss && lock_q;
	assign lossEvt = errEvt && (badRun_q == LOSS_RUN - 3'h1);

	always_ff @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			chkLfsr_q  <= 15'h0;
			lock_q     <= 1'b0;
			matchRun_q <= 6'h0;
			badRun_q   <= 3'h0;
		end else if (!checkEn) begin
			lock_q     <= 1'b0;
			matchRun_q <= 6'h0;
			badRun_q   <= 3'h0;
		end else if (rxStep) begin
			chkLfsr_q <= {chkLfsr_q[13:0], rxBitS_q[1]};
			if (!lock_q) begin
				matchRun_q <= miss ? 6'h0 : matchRun_q + 6'h1;
				lock_q     <= !miss && (matchRun_q == LOCK_RUN - 6'h1);
				badRun_q   <= 3'h0;
			end else if (lossEvt) begin
				lock_q     <= 1'b0;
				matchRun_q <= 6'h0;
				badRun_q   <= 3'h0;
			end else begin
				badRun_q <= miss ? badRun_q + 3'h1 : 3'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// error counter; a read clears it, a same-cycle error still counts
	always_ff @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			errCnt_q     <= 16'h0;
			errWrapPulse <= 1'b0;
		end else begin
			errWrapPulse <= errEvt && mode_q && (errCnt_q == ERR_MAX);
			if (rdDone && hit(paddr, ADR_ERRS)) begin
				errCnt_q <= {15'h0, errEvt};
			end else if (errEvt) begin
				if (errCnt_q != ERR_MAX) begin
					errCnt_q <= errCnt_q + 16'h1;
				end else if (mode_q) begin
					errCnt_q <= 16'h0;
				end
				// mode 0 holds at maximum
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky flags and interrupt; set wins over read clear
	always_ff @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			lossFlag_q <= 1'b0;
			iStat_q    <= '0;
			irq        <= 1'b0;
		end else begin
			lossFlag_q <= lossEvt || (lossFlag_q && !ctrlRd);
			iStat_q    <= {doneEvt, errWrapPulse, lossEvt}
				| (iStat_q & {IRQ_W{!(rdDone && hit(paddr, ADR_ISTAT))}});
			irq        <= |(iStat_q & iMask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	a_wrap_restart: assert property (errEvt && mode_q && errCnt_q == ERR_MAX
		&& !rdDone |=> errCnt_q == 16'h0 && errWrapPulse) else $error("no wrap");
	a_count_hold: assert property (!mode_q && errCnt_q == ERR_MAX && !rdDone
		|=> errCnt_q == ERR_MAX && !errWrapPulse) else $error("no hold");
	a_gap_resend: assert property (pktEnd && en_q && type_q
		|=> genState_q == G_GAP) else $error("no gap");
	a_const_once: assert property (doneEvt && en_q |=> (genState_q == G_IDLE)
		[*3]) else $error("const repeats");
	a_gen_stop: assert property (!en_q |=> genState_q == G_IDLE)
		else $error("gen not off");
	a_lock_read: assert property (access && !pready && !pwrite && hit(paddr, ADR_CTRL)
		|=> prdata[B_LOCK] == $past(lock_q)) else $error("lock bit");
	a_loss_latch: assert property (lossEvt |=> lossFlag_q && !lock_q)
		else $error("loss lost");
	a_gen_status: assert property (access && !pready && !pwrite && hit(paddr, ADR_CTRL)
		|=> prdata[B_GACT] == ($past(genState_q) != G_IDLE)) else $error("status");
	a_loop_pcs: assert property (sel_q == LB_PCS |=> loopSel.pcs && !loopSel.analog)
		else $error("pcs decode");
	a_line_gate: assert property (macLoopActive && !fwd_q |=> !lineTxEn ##1 !txValid)
		else $error("line open");
	a_fwd_accept: assert property (!macLoopActive && !fwd_q |=> !fwd_q)
		else $error("fwd taken");
endmodule

// *** test_pbc_bist_ctrl.sv ***
// self-checking bench for the prbs self-test and loopback control block
// assumes pbc_pkg compiled first; tx is looped back to rx through one flop
`timescale 1ns/10ps
module test_pbc_bist_ctrl;
	import pbc_pkg::*;
	logic         ref_clk, rstn, psel, penable, pwrite, pready, pslverr, lastErr;
	logic         rxBit, rxValid, txBit, txValid, lineTxEn, macLoopActive, inj;
	logic         errWrapPulse, irq;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, rdata;
	logic [3:0]   pstrb, code;
	pbc_loop_type loopSel;
	int           errorCnt, checksDone, seed, k, txCnt, badBits;

	pbc_bist_ctrl i_pbc_bist_ctrl (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.rxBit(rxBit), .rxValid(rxValid), .txBit(txBit), .txValid(txValid),
		.lineTxEn(lineTxEn), .macLoopActive(macLoopActive), .loopSel(loopSel),
		.errWrapPulse(errWrapPulse), .irq(irq));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////
	// released line shows a toggling level, never the last bit
	always @(posedge ref_clk) begin
		rxBit   <= txValid ? (txBit ^ inj) : ~rxBit;
		rxValid <= txValid;
		if (txValid) begin
			if (txBit !== CONST_BYTE[txCnt % 8])
				badBits <= badBits + 1;
			txCnt <= txCnt + 1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checksDone++;
		if (seen !== exp) begin
			errorCnt++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic apb(input logic isWr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= isWr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdata   = prdata;
		lastErr = pslverr;
		if (n >= 20)
			check(32'h0, 32'h1, "apb answer");
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	function automatic logic [31:0] expLoop(input logic [3:0] c);
		return {29'h0, c == LB_PCS, c == LB_ANALOG, c == LB_REVERSE};
	endfunction

	task automatic waitTx;
		int n;
		n = 0;
		while (txValid !== 1'b1 && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", checksDone, errorCnt);
		if (errorCnt == 0 && checksDone > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#(20 * 40000);
		errorCnt++;
		conclude();
	end

	initial begin
		seed = 16;
		{rstn, psel, penable, pwrite, macLoopActive, inj, rxBit, rxValid} = '0;
		paddr  = '0;
		pwdata = '0;
		pstrb  = 4'hf;
		txCnt = 0;
		badBits = 0;
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd(ADR_CTRL);
		check(rdata, {16'h0, CTRL_RESET}, "control reset");
		check(lineTxEn, 1'b1, "line enable reset");
		rd(12'h3fc);
		check({lastErr, rdata[30:0]}, 32'h80000000, "unmapped read");
		$display("test reset done");
		// none, pcs, analog and reverse, then reserved 1000, then four random codes
		for (k = 0; k < 9; k++) begin
			code = (k < 4) ? 4'(1 << k) >> 1 : (k == 4) ? 4'h8 : 4'($random(seed));
			wr(ADR_CTRL, {26'h0, code, 2'h0});
			rd(ADR_CTRL);
			check({29'h0, loopSel}, expLoop(code), "loopback decode");
			check(rdata[5:2], code, "loopback readback");
		end
		$display("test loopback done");
		wr(ADR_CTRL, 32'h40);
		rd(ADR_CTRL);
		check(rdata[B_FWD], 1'b0, "forward refused");
		macLoopActive <= 1'b1;
		wr(ADR_CTRL, 32'h40);
		rd(ADR_CTRL);
		check({rdata[B_FWD], lineTxEn}, 2'b11, "forward kept");
		wr(ADR_CTRL, 32'h0);
		// gate flop follows the forward bit one cycle later
		@(posedge ref_clk);
		check(lineTxEn, 1'b0, "line suppressed");
		macLoopActive <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check(lineTxEn, 1'b1, "line restored");
		$display("test forwarding done");
		////////////////////////////////////////////////////////////////////
		wr(ADR_IMASK, 32'h1 << I_LOSS);
		wr(ADR_CTRL, (32'h1 << B_MODE) | (32'h1 << B_TYPE) | (32'h1 << B_EN));
		waitTx();
		rd(ADR_CTRL);
		check({rdata[14:12], rdata[B_GACT]}, 4'hf, "generator running");
		for (k = 0; k < 80 && rdata[B_LOCK] !== 1'b1; k++)
			rd(ADR_CTRL);
		check(rdata[B_LOCK], 1'b1, "checker locked");
		rd(ADR_ERRS);
		for (k = 0; k < 5; k++) begin
			waitTx();
			inj <= 1'b1;
			@(posedge ref_clk);
			inj <= 1'b0;
			repeat (20 + ($random(seed) & 15)) @(posedge ref_clk);
		end
		repeat (40) @(posedge ref_clk);
		rd(ADR_ERRS);
		check(rdata[15:0] != 16'h0, 1'b1, "errors counted");
		check(errWrapPulse, 1'b0, "no wrap below max");
		rd(ADR_CTRL);
		check({irq, rdata[B_LOSS]}, 2'b00, "no loss yet");
		$display("test continuous done");
		waitTx();
		inj <= 1'b1;
		// count corrupted bits on the line, so a packet gap cannot swallow them
		repeat (12) begin
			waitTx();
			@(posedge ref_clk);
		end
		inj <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check(irq, 1'b1, "irq on loss");
		rd(ADR_ISTAT);
		check(rdata[2:0], 3'h1, "loss status");
		repeat (3) @(posedge ref_clk);
		check(irq, 1'b0, "irq cleared");
		rd(ADR_CTRL);
		check(rdata[B_LOSS], 1'b1, "loss latched");
		rd(ADR_CTRL);
		check(rdata[B_LOSS], 1'b0, "loss cleared by read");
		$display("test sync loss done");
		wr(ADR_CTRL, 32'h0);
		repeat (3) @(posedge ref_clk);
		rd(ADR_CTRL);
		check({txValid, rdata[B_GACT]}, 2'b00, "generator off");
		rd(ADR_ISTAT);
		txCnt <= 0;
		badBits <= 0;
		wr(ADR_CTRL, 32'h1 << B_EN);
		rd(ADR_CTRL);
		check(rdata[B_GACT], 1'b1, "single active");
		repeat (800) @(posedge ref_clk);
		check(txCnt, 32'(PKT_LEN), "single packet length");
		check(badBits, 0, "constant data");
		rd(ADR_CTRL);
		check({rdata[B_LOCK], rdata[B_GACT]}, 2'b00, "single done");
		rd(ADR_ISTAT);
		check(rdata[I_DONE], 1'b1, "done status");
		$display("test single packet done");
		conclude();
	end
endmodule
